// file: stc_pkg.sv
// ---------------------------------------------------------------
// Statistics counter unit shared definitions
// ---------------------------------------------------------------
package stc_pkg;

   // Counter geometry
   localparam int          STC_CNT_W      = 32;
   localparam int          STC_NUM_CNT    = 21;
   localparam int          STC_NUM_BASIC  = 16;
   localparam int          STC_IDX_W      = 5;
   localparam int          STC_ADDR_W     = 8;
   localparam logic [31:0] STC_CNT_RST    = 32'h0000_0000;
   localparam logic [31:0] STC_CNT_MAX    = 32'hffff_ffff;

   // Counter indices of the event vector
   localparam logic [4:0]  STC_IX_MAX_COLL_ABORT = 5'h01;
   localparam logic [4:0]  STC_IX_FC_TX   = 5'h10;
   localparam logic [4:0]  STC_IX_FC_RX   = 5'h11;
   localparam logic [4:0]  STC_IX_FC_UNS  = 5'h12;
   localparam logic [4:0]  STC_IX_MGT_RX  = 5'h13;
   localparam logic [4:0]  STC_IX_MGT_TX  = 5'h14;

   // Dump byte stride and offsets; only the management transmit offset breaks the four byte stride
   localparam logic [7:0]  STC_ID_STRIDE  = 8'h04;
   localparam logic [7:0]  STC_ID_MGT_TX  = 8'h4e;
   localparam logic [7:0]  STC_ID_LAST16  = 8'h3c;

   typedef logic [STC_NUM_CNT-1:0] stc_evt_t;

   // One word written to the dump buffer
   typedef struct packed {
      logic [STC_ADDR_W-1:0] addr;
      logic [STC_CNT_W-1:0]  data;
   } stc_memwr_s;

   typedef enum logic [1:0] {
      STC_ST_IDLE = 2'h0,
      STC_ST_DUMP = 2'h1
   } stc_state_e;

endpackage : stc_pkg

// file: stc_counters.sv
// Function
// RQ1 - Counter 64 counts transmitted pause frames, stop and resume alike.
// RQ2 - Counter 68 counts received pause frames, stop and resume alike.
// RQ3 - Counter 72 counts valid received control frames with an unsupported opcode.
// RQ4 - Counter 76 counts received management packets.
// RQ5 - Counter 78 counts transmitted management packets.
// RQ6 - Reset clears every counter; no way exists to preload a value.
// RQ7 - Update reads the counter internally, adds one and writes it back.
// RQ8 - Counters wrap from all ones to zero, never saturate.
// RQ9 - Every counter is 32 bits wide.
// RQ10 - One frame may raise several counters at once; all are updated.
// RQ11 - Host dump command copies a snapshot of the counters into memory.
// RQ12 - 21 counters held; a dump writes 16 or 21 per configuration.
// RQ13 - Counter 4 counts frames abandoned at the maximum collision count.
// RQ14 - Dump writes in ascending identifier order at offset equal to identifier.
// RQ15 - Simultaneous increments are queued and served one by one, none lost; a repeat event for a counter already queued merges into one.
`timescale 1ns/10ps
`default_nettype none

module stc_counters
   import stc_pkg::*;
(
   input  wire logic       sys_clk_i,       // 10 MHz core clock
   input  wire logic       reset_i,         // Synchronous reset, active high
   input  wire stc_evt_t   evt_i,           // One-cycle increment pulses, one per counter
   input  wire logic       dump_req_i,      // Dump command pulse from control block
   input  wire logic       ext_stats_i,     // Extended statistics configured
   input  wire logic       mgt_stats_i,     // Management statistics configured
   output logic            mem_wr_valid_o,  // Dump word valid
   input  wire logic       mem_wr_ready_i,  // Memory accepts dump word
   output stc_memwr_s      mem_wr_o,        // Dump word offset and value
   output logic            dump_busy_o,     // Dump in progress
   output logic            dump_done_o      // Last dump word accepted
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------

   // Lowest pending counter wins; fixed priority is fine since each
   // counter is served within one pass of the queue
   function automatic logic [STC_IDX_W-1:0] first_set(input stc_evt_t v);
      logic [STC_IDX_W-1:0] r;
      r = '0;
      for (int i = STC_NUM_CNT - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = STC_IDX_W'(i);
         end
      end
      return r;
   endfunction

   // Byte offset of a counter in the dump buffer
   function automatic logic [STC_ADDR_W-1:0] cnt_offset(input logic [STC_IDX_W-1:0] ix);
      logic [STC_ADDR_W-1:0] r;
      r = STC_ADDR_W'(ix) * STC_ID_STRIDE;
      if (ix == STC_IX_MGT_TX)
      begin
         r = STC_ID_MGT_TX;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Storage and control state
   // ---------------------------------------------------------------
   logic [STC_CNT_W-1:0] cnt_mem [STC_NUM_CNT];
   stc_evt_t             pend_reg;
   stc_state_e           state_reg;
   logic [STC_IDX_W-1:0] dix_reg;
   logic [STC_IDX_W-1:0] dlast_reg;
   logic                 valid_reg;
   logic                 done_reg;
   stc_memwr_s           wr_reg;

   logic                 upd_vld;
   logic [STC_IDX_W-1:0] upd_idx;
   logic [STC_CNT_W-1:0] upd_old;
   logic                 wr_fire;
   logic                 dump_start;

   // Increments are held back while a dump runs, and on the edge that starts
   // one, so no counter changes between the first word and the rest
   assign upd_vld    = (pend_reg != '0) && (state_reg == STC_ST_IDLE) && !dump_req_i; // [RQ15]
   assign upd_idx    = first_set(pend_reg);
   assign upd_old    = cnt_mem[upd_idx];
   assign wr_fire    = valid_reg && mem_wr_ready_i;
   assign dump_start = dump_req_i && (state_reg == STC_ST_IDLE);        // [RQ11]

   // ---------------------------------------------------------------
   // Increment queue
   // ---------------------------------------------------------------

   // A new event beats the clear of its own bit; a second event for a
   // counter already queued merges, so producers must space them
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         pend_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < STC_NUM_CNT; i++)
         begin
            // Frame events for 4, 64..78 and all others land here [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ13]
            if (evt_i[i])
            begin
               pend_reg[i] <= 1'b1;                                     // [RQ10]
            end
            else if (upd_vld && (upd_idx == STC_IDX_W'(i)))
            begin
               pend_reg[i] <= 1'b0;                                     // [RQ15]
            end
         end
      end
   end

   // Read-modify-write of one counter per cycle, invisible to the host
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < STC_NUM_CNT; i++)
         begin
            cnt_mem[i] <= STC_CNT_RST;                                  // [RQ6]
         end
      end
      else if (upd_vld)
      begin
         // 32-bit add drops the carry so all ones goes to zero [RQ7] [RQ8] [RQ9]
         cnt_mem[upd_idx] <= upd_old + STC_CNT_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // Dump sequencer
   // ---------------------------------------------------------------

   // Dump length is fixed at command time; a command while busy is ignored
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_reg <= STC_ST_IDLE;
         dix_reg   <= '0;
         dlast_reg <= '0;
      end
      else
      begin
         unique case (state_reg)
            STC_ST_IDLE:
            begin
               if (dump_start)
               begin
                  state_reg <= STC_ST_DUMP;
                  dix_reg   <= '0;
                  // Short dump unless both statistics options are on [RQ12]
                  dlast_reg <= (ext_stats_i && mgt_stats_i) ?
                               STC_IDX_W'(STC_NUM_CNT - 1) :
                               STC_IDX_W'(STC_NUM_BASIC - 1);
               end
            end
            STC_ST_DUMP:
            begin
               if (wr_fire)
               begin
                  if (dix_reg == dlast_reg)
                  begin
                     state_reg <= STC_ST_IDLE;
                  end
                  dix_reg <= dix_reg + STC_IDX_W'(1);                   // [RQ14]
               end
            end
         endcase
      end
   end

   // Dump word register; next word loads as the current one is taken
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         valid_reg <= 1'b0;
         wr_reg    <= '0;
      end
      else if (dump_start)
      begin
         valid_reg   <= 1'b1;
         wr_reg.addr <= cnt_offset('0);
         wr_reg.data <= cnt_mem[0];
      end
      else if (wr_fire)
      begin
         valid_reg   <= (dix_reg != dlast_reg);
         wr_reg.addr <= cnt_offset(dix_reg + STC_IDX_W'(1));            // [RQ14]
         wr_reg.data <= cnt_mem[STC_IDX_W'(dix_reg + STC_IDX_W'(1)) % STC_IDX_W'(STC_NUM_CNT)];
      end
   end

   // Completion pulse one cycle after the last word is accepted
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= wr_fire && (dix_reg == dlast_reg);                 // [RQ11]
      end
   end

   assign mem_wr_valid_o = valid_reg;
   assign mem_wr_o       = wr_reg;
   assign dump_busy_o    = (state_reg == STC_ST_DUMP);
   assign dump_done_o    = done_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_dump_cmd_full;
      dump_start && ext_stats_i && mgt_stats_i;
   endsequence

   sequence s_first_word;
      valid_reg && (wr_reg.addr == 8'h00) && (state_reg == STC_ST_DUMP);
   endsequence

   AST_RESET_CLEARS: assert property (@(posedge sys_clk_i)       // [RQ6]
      reset_i |=> (cnt_mem[0] == 32'h0) && (cnt_mem[20] == 32'h0) && (pend_reg == '0))
      else $error("Counters not cleared by reset");

   AST_INCREMENT: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ7]
      upd_vld && (upd_old != STC_CNT_MAX) |=> cnt_mem[$past(upd_idx)] == $past(upd_old) + 32'h1)
      else $error("Counter did not advance by one");

   AST_WRAP: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ8]
      upd_vld && (upd_old == STC_CNT_MAX) |=> cnt_mem[$past(upd_idx)] == 32'h0)
      else $error("Counter did not wrap to zero");

   AST_FC_TX_QUEUED: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ1]
      evt_i[STC_IX_FC_TX] |=> pend_reg[STC_IX_FC_TX])
      else $error("Pause transmit event lost");

   AST_MGT_RX_QUEUED: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ4]
      evt_i[STC_IX_MGT_RX] |=> pend_reg[STC_IX_MGT_RX])
      else $error("Management receive event lost");

   AST_SERVE_IDLE: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ15]
      (pend_reg != '0) && (state_reg == STC_ST_IDLE) && !dump_req_i && (evt_i == '0)
      |=> ($countones(pend_reg) + 1) == $countones($past(pend_reg)))
      else $error("Queued increment not served");

   AST_FROZEN_DUMP: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ11]
      (state_reg == STC_ST_DUMP) |=> $stable(cnt_mem[STC_IX_FC_RX]) && $stable(cnt_mem[0]))
      else $error("Counter changed during dump");

   AST_DUMP_START: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ14]
      s_dump_cmd_full |=> s_first_word)
      else $error("Dump did not start at offset zero");

   AST_DUMP_SHORT: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ12]
      wr_fire && (wr_reg.addr == STC_ID_LAST16) && (dlast_reg == 5'h0f)
      |=> !valid_reg && dump_done_o && (state_reg == STC_ST_IDLE))
      else $error("Short dump did not end after sixteen words");

   AST_DUMP_TAIL: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RQ14]
      wr_fire && (wr_reg.addr == 8'h4c) |=> valid_reg && (wr_reg.addr == STC_ID_MGT_TX))
      else $error("Management transmit word misplaced");

endmodule // stc_counters

`default_nettype wire

// file: stc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Host memory that takes the counter dump words
// ---------------------------------------------------------------
module stc_mem_model
   import stc_pkg::*;
(
   input  wire logic       sys_clk_i,       // Core clock
   input  wire logic       reset_i,         // Synchronous reset, active high
   input  wire logic       slow_i,          // Stall at random when high
   input  wire logic       mem_wr_valid_i,  // Dump word offered
   input  wire stc_memwr_s mem_wr_i,        // Dump word offset and value
   output logic            mem_wr_ready_o   // Word taken at this edge
);
   logic [31:0] mem_reg [0:255];

   // Random stalls force the dump to hold each word until it is taken
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         mem_wr_ready_o <= 1'b0;
      else
         mem_wr_ready_o <= slow_i ? 1'($urandom_range(1, 0)) : 1'b1;
   end

   // Snapshot lands at the byte offset carried with each word
   always_ff @(posedge sys_clk_i)
   begin
      if (mem_wr_valid_i && mem_wr_ready_o)
         mem_reg[mem_wr_i.addr] <= mem_wr_i.data;
   end
endmodule // stc_mem_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Self-checking bench for the statistics counter unit
// ---------------------------------------------------------------
module testbench
   import stc_pkg::*;
();
   logic        sys_clk_i = 1'b0;
   logic        reset_i;
   stc_evt_t    evt_i;
   logic        dump_req_i;
   logic        ext_stats_i;
   logic        mgt_stats_i;
   logic        slow;
   logic        mem_wr_valid_o;
   logic        mem_wr_ready_i;
   stc_memwr_s  mem_wr_o;
   logic        dump_busy_o;
   logic        dump_done_o;
   logic [31:0] cnt [STC_NUM_CNT];
   stc_memwr_s  exp_q [$];
   int          errors = 0;
   int          total_checks = 0;
   int          cycles = 0;

   stc_counters DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .evt_i(evt_i),
      .dump_req_i(dump_req_i), .ext_stats_i(ext_stats_i), .mgt_stats_i(mgt_stats_i),
      .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
      .mem_wr_o(mem_wr_o), .dump_busy_o(dump_busy_o), .dump_done_o(dump_done_o));
   stc_mem_model u_mem (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .slow_i(slow),
      .mem_wr_valid_i(mem_wr_valid_o), .mem_wr_i(mem_wr_o), .mem_wr_ready_o(mem_wr_ready_i));

   // 10 MHz core clock
   always #50 sys_clk_i = ~sys_clk_i;

   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Each accepted dump word is matched against the oldest note
   always @(posedge sys_clk_i)
   begin
      if (!reset_i && mem_wr_valid_o === 1'b1 && mem_wr_ready_i === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk("pending_words", 40'h1, 40'h0);
         else
            chk("dump_word", exp_q.pop_front(), mem_wr_o);
      end
   end

   // Cut a hang short; a full run takes under 2000 cycles
   always @(posedge sys_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         errors++;
         complete_run();
      end
   end

   // A pulse mid-dump must wait, and a second command while busy is dropped
   task automatic run_dump(input logic ext, input logic mgt, input int n);
      int b;
      logic [7:0] la;
      b = $urandom_range(20, 0);
      la = (n == 21) ? STC_ID_MGT_TX : 8'(4 * n - 4);
      for (int i = 0; i < n; i++)
         exp_q.push_back(stc_memwr_s'{addr: (i == 20) ? STC_ID_MGT_TX : 8'(4 * i), data: cnt[i]});
      dump_req_i <= 1'b1;
      ext_stats_i <= ext;
      mgt_stats_i <= mgt;
      @(posedge sys_clk_i);
      dump_req_i <= 1'b0;
      evt_i[b] <= 1'b1;
      @(posedge sys_clk_i);
      chk("dump_busy", 40'h1, 40'(dump_busy_o));
      evt_i <= '0;
      dump_req_i <= 1'b1;
      @(posedge sys_clk_i);
      dump_req_i <= 1'b0;
      for (int k = 0; k < 300 && dump_done_o !== 1'b1; k++)
         @(posedge sys_clk_i);
      chk("dump_done", 40'h1, 40'(dump_done_o));
      chk("words_left", 40'h0, 40'(exp_q.size()));
      chk("mem_last", 40'(cnt[n - 1]), 40'(u_mem.mem_reg[la]));
      @(posedge sys_clk_i);
      chk("done_pulse", 40'h0, 40'(dump_done_o));
      repeat (24) @(posedge sys_clk_i);
      chk("dump_busy", 40'h0, 40'(dump_busy_o));
      cnt[b] += 32'h1;
      $display("test dump %0d words finished", n);
   endtask

   // First mask sets all counters at once, the rest are random
   task automatic run_events(input int n);
      logic [20:0] m;
      for (int j = 0; j < n; j++)
      begin
         m = (j == 0) ? '1 : 21'($urandom);
         evt_i <= m;
         @(posedge sys_clk_i);
         evt_i <= '0;
         repeat (22) @(posedge sys_clk_i);
         for (int i = 0; i < 21; i++)
            cnt[i] += 32'(m[i]);
         chk("quiet_bus", 40'h0, 40'(mem_wr_valid_o));
      end
      run_dump(1'b1, 1'b1, 21);
      $display("test events finished");
   endtask

   // Main sequence
   initial
   begin
      void'($urandom(40694));
      reset_i = 1'b1;
      evt_i = '0;
      dump_req_i = 1'b0;
      ext_stats_i = 1'b0;
      mgt_stats_i = 1'b0;
      slow = 1'b0;
      foreach (cnt[i]) cnt[i] = '0;
      repeat (4) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      run_dump(1'b1, 1'b1, 21);
      run_events(12);
      slow <= 1'b1;
      run_dump(1'b1, 1'b0, 16);
      run_dump(1'b0, 1'b1, 16);
      run_events(4);
      run_dump(1'b0, 1'b0, 16);
      reset_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      foreach (cnt[i]) cnt[i] = '0;
      run_dump(1'b1, 1'b1, 21);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
